// [src/pll_cfg_defs.vh]
// constants for the pll configuration word decoder
`ifndef PLL_CFG_DEFS_VH
`define PLL_CFG_DEFS_VH

// register indices on the plain register port
`define ADDR_W 3
`define ADDR_CFG_PRIMARY 3'h0
`define ADDR_CFG_ALTERNATE 3'h1
`define ADDR_SERIAL_LOW 3'h2
`define ADDR_SERIAL_HIGH 3'h3
`define ADDR_DECODED 3'h4
`define ADDR_LOAD_CTRL 3'h5

// reload request bit of the control write
`define BIT_RELOAD 0

// field positions of the pll configuration word
`define BIT_USB_FSEL 30
`define ODIV_HI 18
`define ODIV_LO 16
`define MULT_HI 14
`define MULT_LO 8
`define BIT_ICLK 7
`define RNG_HI 6
`define RNG_LO 4
`define IDIV_HI 2
`define IDIV_LO 0

// reserved positions, must read as ones
`define RESERVED_MASK 32'hBFF88008

// erased flash reads all ones
`define ERASED_WORD 32'hFFFFFFFF

// output divisor codes
`define ODIV_DIV2_A 3'h0
`define ODIV_DIV2_B 3'h1
`define ODIV_DIV4 3'h2
`define ODIV_DIV8 3'h3
`define ODIV_DIV16 3'h4
// log2 of divisors
`define LOG_DIV2 3'h1
`define LOG_DIV4 3'h2
`define LOG_DIV8 3'h3
`define LOG_DIV16 3'h4
`define LOG_DIV32 3'h5

// range codes
`define RNG_BYPASS 3'h0
`define RNG_LAST_VALID 3'h5

// reset values of the decoded outputs
`define MULT_RESET 8'h01
`define IDIV_RESET 3'h0

// usb pll input frequencies in MHz
`define USB_IN_24MHZ 8'h18
`define USB_IN_12MHZ 8'h0C

`endif

// [src/pll_word_field.v]
// extracts and decodes fields of one pll configuration word
module pll_word_field (
  // word in
  input wire [31:0] word,
  // decoded fields
  output wire usb_in_24mhz,
  output wire [7:0] usb_in_mhz,
  output reg [2:0] odiv_log2,
  output wire [7:0] mult_value,
  output wire src_fast_rc,
  output wire [2:0] range_code,
  output wire range_bypass,
  output wire range_reserved,
  output wire [2:0] in_divider,
  output wire reserved_ok
);
`include "pll_cfg_defs.vh"

  wire [2:0] odiv_code;

  assign usb_in_24mhz = word[`BIT_USB_FSEL];
  assign usb_in_mhz = usb_in_24mhz ? `USB_IN_24MHZ : `USB_IN_12MHZ;

  assign odiv_code = word[`ODIV_HI:`ODIV_LO];
  always @* begin
    case (odiv_code)
      `ODIV_DIV4: odiv_log2 = `LOG_DIV4;
      `ODIV_DIV8: odiv_log2 = `LOG_DIV8;
      `ODIV_DIV16: odiv_log2 = `LOG_DIV16;
      `ODIV_DIV2_A, `ODIV_DIV2_B: odiv_log2 = `LOG_DIV2;
      default: odiv_log2 = `LOG_DIV32;
    endcase
  end

  assign mult_value = {1'b0, word[`MULT_HI:`MULT_LO]} + 8'h01;

  assign src_fast_rc = word[`BIT_ICLK];

  // range field and its reserved codes
  assign range_code = word[`RNG_HI:`RNG_LO];
  assign range_bypass = (range_code == `RNG_BYPASS);
  assign range_reserved = (range_code > `RNG_LAST_VALID);

  assign in_divider = word[`IDIV_HI:`IDIV_LO];

  assign reserved_ok = ((word & `RESERVED_MASK) == `RESERVED_MASK);
endmodule

// [src/pll_config_word_decoder.v]
// decodes the boot pll configuration word and exposes it on a register port
//
// Added by the designer: the register addresses and the strobed register port.
`include "pll_cfg_defs.vh"

// Operation
// - use lower boot alias configuration space
// - bit 30 picks 24 or 12 MHz
// - bits 18-16 divide output, 2 to 32
// - bits 14-8 multiply by value plus one
// - bit 7 picks fast rc or primary
// - bits 6-4 encode input frequency range
// - two read-only serial number registers
module pll_config_word_decoder #(
  parameter SERIAL_LOW_VALUE = 32'h00000000,
  parameter SERIAL_HIGH_VALUE = 32'h00000000
) (
  // clock and reset
  input wire CLK_SYS,
  input wire RST,
  // configuration words from the two boot flash spaces
  input wire [31:0] BOOT1_CFG_WORD,
  input wire [31:0] BOOT2_CFG_WORD,
  input wire LOWER_ALIAS_IS_BOOT2,
  input wire CFG_VALID,
  // register port
  input wire [`ADDR_W-1:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [31:0] RDATA,
  // decoded clock settings
  output reg USB_PLL_IN_24MHZ,
  output reg [2:0] SYS_PLL_ODIV_LOG2,
  output reg [7:0] SYS_PLL_MULT,
  output reg SYS_PLL_SRC_FAST_RC,
  output reg [2:0] SYS_PLL_RANGE,
  output reg SYS_PLL_BYPASS,
  output reg [2:0] SYS_PLL_IN_DIV,
  output reg CFG_LOADED,
  output reg CFG_FAULT
);

  ////////////////////////////////////////////////////////////
  // load of the active configuration word

  reg [31:0] pll_default_config_word;
  reg [31:0] alternate_pll_config_word;
  reg loaded;
  reg reload_req;
  wire [31:0] lower_word;
  wire [31:0] upper_word;

  // lower alias space selects the active word
  assign lower_word = LOWER_ALIAS_IS_BOOT2 ? BOOT2_CFG_WORD : BOOT1_CFG_WORD;
  assign upper_word = LOWER_ALIAS_IS_BOOT2 ? BOOT1_CFG_WORD : BOOT2_CFG_WORD;

  // words are captured once after reset; software may request a reload
  always @(posedge CLK_SYS) begin
    if (RST) begin
      pll_default_config_word <= `ERASED_WORD;
      alternate_pll_config_word <= `ERASED_WORD;
      loaded <= 1'b0;
      reload_req <= 1'b0;
    end else begin
      if (CFG_VALID && (!loaded || reload_req)) begin
        pll_default_config_word <= lower_word;
        alternate_pll_config_word <= upper_word;
        loaded <= 1'b1;
        reload_req <= 1'b0;
      end
      // a request in a capture cycle survives, so words changed meanwhile are still taken
      if (WR && ADDR == `ADDR_LOAD_CTRL && WDATA[`BIT_RELOAD])
        reload_req <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////
  // field decode

  wire usb_in_24mhz;
  wire [7:0] usb_in_mhz;
  wire [2:0] odiv_log2;
  wire [7:0] mult_value;
  wire src_fast_rc;
  wire [2:0] range_code;
  wire range_bypass;
  wire range_reserved;
  wire [2:0] in_divider;
  wire reserved_ok;

  pll_word_field u_field (
    .word(pll_default_config_word),
    .usb_in_24mhz(usb_in_24mhz),
    .usb_in_mhz(usb_in_mhz),
    .odiv_log2(odiv_log2),
    .mult_value(mult_value),
    .src_fast_rc(src_fast_rc),
    .range_code(range_code),
    .range_bypass(range_bypass),
    .range_reserved(range_reserved),
    .in_divider(in_divider),
    .reserved_ok(reserved_ok)
  );

  // fault: reserved bit cleared or reserved range code; outputs still follow the word
  wire fault = !reserved_ok || range_reserved;

  always @(posedge CLK_SYS) begin
    if (RST) begin
      USB_PLL_IN_24MHZ <= 1'b0;
      SYS_PLL_ODIV_LOG2 <= `LOG_DIV2;
      SYS_PLL_MULT <= `MULT_RESET;
      SYS_PLL_SRC_FAST_RC <= 1'b0;
      SYS_PLL_RANGE <= `RNG_BYPASS;
      SYS_PLL_BYPASS <= 1'b1;
      SYS_PLL_IN_DIV <= `IDIV_RESET;
      CFG_LOADED <= 1'b0;
      CFG_FAULT <= 1'b0;
    end else begin
      USB_PLL_IN_24MHZ <= usb_in_24mhz;
      SYS_PLL_ODIV_LOG2 <= odiv_log2;
      SYS_PLL_MULT <= mult_value;
      SYS_PLL_SRC_FAST_RC <= src_fast_rc;
      SYS_PLL_RANGE <= range_code;
      SYS_PLL_BYPASS <= range_bypass;
      SYS_PLL_IN_DIV <= in_divider;
      CFG_LOADED <= loaded;
      CFG_FAULT <= loaded && fault;
    end
  end

  ////////////////////////////////////////////////////////////
  // register read port; all registers read-only, writes ignored except reload

  reg [31:0] next_rdata;

  always @* begin
    case (ADDR)
      `ADDR_CFG_PRIMARY: next_rdata = pll_default_config_word;
      `ADDR_CFG_ALTERNATE: next_rdata = alternate_pll_config_word;
      `ADDR_SERIAL_LOW: next_rdata = SERIAL_LOW_VALUE;
      `ADDR_SERIAL_HIGH: next_rdata = SERIAL_HIGH_VALUE;
      `ADDR_DECODED: next_rdata = {usb_in_mhz, mult_value, 3'h0, range_reserved,
                                   reserved_ok, odiv_log2, src_fast_rc, range_code, 1'b0, in_divider};
      `ADDR_LOAD_CTRL: next_rdata = {29'h00000000, fault, reload_req, loaded};
      default: next_rdata = 32'h00000000;
    endcase
  end

  always @(posedge CLK_SYS) begin
    if (RST)
      RDATA <= 32'h00000000;
    else if (RD)
      RDATA <= next_rdata;
    else
      RDATA <= 32'h00000000;
  end
endmodule

// [test/pll_config_word_decoder_chk.sv]
// port assertions for the pll configuration word decoder
`include "pll_cfg_defs.vh"
module pll_config_word_decoder_chk #(
  parameter SERIAL_LOW_VALUE = 32'h0,
  parameter SERIAL_HIGH_VALUE = 32'h0
) (
  input wire CLK_SYS,
  input wire RST,
  input wire [31:0] BOOT1_CFG_WORD,
  input wire [31:0] BOOT2_CFG_WORD,
  input wire LOWER_ALIAS_IS_BOOT2,
  input wire CFG_VALID,
  input wire [`ADDR_W-1:0] ADDR,
  input wire RD,
  input wire [31:0] RDATA,
  input wire USB_PLL_IN_24MHZ,
  input wire [2:0] SYS_PLL_ODIV_LOG2,
  input wire [7:0] SYS_PLL_MULT,
  input wire SYS_PLL_SRC_FAST_RC,
  input wire [2:0] SYS_PLL_RANGE,
  input wire SYS_PLL_BYPASS,
  input wire [2:0] SYS_PLL_IN_DIV,
  input wire CFG_LOADED,
  input wire CFG_FAULT
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // holds only while the lower alias word changes under reset alone
  wire [31:0] w = LOWER_ALIAS_IS_BOOT2 ? BOOT2_CFG_WORD : BOOT1_CFG_WORD;
  wire [2:0] od = w[18:16] < 3'h2 ? 3'h1 : (w[18:16] > 3'h4 ? 3'h5 : w[18:16]);
  wire bad = (w & `RESERVED_MASK) != `RESERVED_MASK || w[6:5] == 2'b11;
  a_usb_freq: assert property (CFG_LOADED |-> USB_PLL_IN_24MHZ == w[30])
    else $error("usb input frequency wrong");
  a_odiv_map: assert property (CFG_LOADED |-> SYS_PLL_ODIV_LOG2 == od)
    else $error("output divisor wrong");
  a_mult_plus: assert property (CFG_LOADED |-> SYS_PLL_MULT == {1'b0, w[14:8]} + 8'h01)
    else $error("multiplier wrong");
  a_src_sel: assert property (CFG_LOADED |-> SYS_PLL_SRC_FAST_RC == w[7])
    else $error("input source wrong");
  a_range_out: assert property (CFG_LOADED |-> SYS_PLL_RANGE == w[6:4] && SYS_PLL_BYPASS == (w[6:4] == 3'h0))
    else $error("range or bypass wrong");
  a_idiv_pass: assert property (CFG_LOADED |-> SYS_PLL_IN_DIV == w[2:0])
    else $error("input divider wrong");
  a_fault_flag: assert property (CFG_LOADED |-> CFG_FAULT == bad)
    else $error("fault flag wrong");
  a_load_time: assert property ($rose(CFG_VALID) && !CFG_LOADED |-> ##[1:3] CFG_LOADED)
    else $error("word not loaded in time");
  a_serial_low: assert property (RD && ADDR == `ADDR_SERIAL_LOW |=> RDATA == SERIAL_LOW_VALUE)
    else $error("serial low read wrong");
  a_serial_high: assert property (RD && ADDR == `ADDR_SERIAL_HIGH |=> RDATA == SERIAL_HIGH_VALUE)
    else $error("serial high read wrong");
  a_rdata_idle: assert property (!RD |=> RDATA == 32'h0)
    else $error("read data not zero");
endmodule
bind pll_config_word_decoder pll_config_word_decoder_chk #(
  .SERIAL_LOW_VALUE(SERIAL_LOW_VALUE),
  .SERIAL_HIGH_VALUE(SERIAL_HIGH_VALUE)
) chk (.*);

// [test/pll_config_word_decoder_tb.sv]
// self-checking bench for the pll configuration word decoder
`include "pll_cfg_defs.vh"
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin fail_count++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module pll_config_word_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // serial values are arbitrary
  localparam [31:0] SN_LO = 32'h13572468, SN_HI = 32'h2468ACE0;
  reg clk = 0, rst = 1, alt = 0, vld = 0, wr = 0, rd = 0;
  reg [31:0] b1 = 0, b2 = 0, wd = 0, seed = 91, w, u, dec;
  reg [20:0] m;
  reg [2:0] addr = 0;
  wire [31:0] rdata;
  wire usb, src, byp, ld, flt;
  wire [2:0] od, rng, idv;
  wire [7:0] mul;
  integer fail_count = 0, checked = 0, cyc = 0, n, j;
  pll_config_word_decoder #(.SERIAL_LOW_VALUE(SN_LO), .SERIAL_HIGH_VALUE(SN_HI)) dut (.CLK_SYS(clk), .RST(rst),
    .BOOT1_CFG_WORD(b1), .BOOT2_CFG_WORD(b2), .LOWER_ALIAS_IS_BOOT2(alt), .CFG_VALID(vld), .ADDR(addr),
    .WDATA(wd), .WR(wr), .RD(rd), .RDATA(rdata), .USB_PLL_IN_24MHZ(usb), .SYS_PLL_ODIV_LOG2(od),
    .SYS_PLL_MULT(mul), .SYS_PLL_SRC_FAST_RC(src), .SYS_PLL_RANGE(rng), .SYS_PLL_BYPASS(byp),
    .SYS_PLL_IN_DIV(idv), .CFG_LOADED(ld), .CFG_FAULT(flt));
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      stop_test;
    end
  end
  ////////////////////////////////////////
  function [31:0] rnd; begin
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    rnd = seed;
  end endfunction
  function [20:0] model(input [31:0] v); reg [2:0] c; begin
    c = v[18:16];
    model = {v[30], c < 3'h2 ? 3'h1 : (c > 3'h4 ? 3'h5 : c), {1'b0, v[14:8]} + 8'h01, v[7], v[6:4],
      v[6:4] == 3'h0, v[2:0], (v & 32'hBFF88008) != 32'hBFF88008 || v[6:5] == 2'b11};
  end endfunction
  task bus_rd(input [2:0] a, input [31:0] e); begin
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK("rdata", e, rdata)
  end endtask
  task bus_wr(input [2:0] a, input [31:0] d); begin
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  end endtask
  // the lower alias word only changes under reset, so the checker may track it
  // words arrive whole, never by single-word program
  task load(input [31:0] a, input [31:0] b, input s); begin
    @(posedge clk);
    rst <= 1'b1;
    vld <= 1'b0;
    b1 <= a;
    b2 <= b;
    alt <= s;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk) vld <= 1'b1;
    for (n = 0; n < 10 && ld !== 1'b1; n++) @(posedge clk) #1;
    `CHK("loaded", 1'b1, ld)
  end endtask
  task stop_test; begin
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  end endtask
  ////////////////////////////////////////
  initial begin
    for (j = 0; j < 8; j++) begin
      w = rnd() | 32'hBFF88008;
      w[18:16] = j[2:0];
      w[6:4] = j[2:0];
      w[14:8] = j == 0 ? 7'h00 : (j == 7 ? 7'h7F : w[14:8]);
      w[3] = j != 5;
      u = rnd();
      if (j[0]) load(u, w, 1'b1);
      else load(w, u, 1'b0);
      m = model(w);
      dec = {w[30] ? 8'h18 : 8'h0C, m[16:9], 3'h0, w[6:5] == 2'b11, (w & 32'hBFF88008) == 32'hBFF88008,
        m[19:17], w[7], w[6:4], 1'b0, w[2:0]};
      `CHK("outputs", m, {usb, od, mul, src, rng, byp, idv, flt})
      bus_rd(`ADDR_CFG_PRIMARY, w);
      bus_rd(`ADDR_CFG_ALTERNATE, u);
      bus_rd(`ADDR_DECODED, dec);
      bus_rd(`ADDR_SERIAL_HIGH, SN_HI);
    end
    bus_wr(`ADDR_SERIAL_LOW, 32'h0);
    bus_rd(`ADDR_SERIAL_LOW, SN_LO);
    bus_rd(3'h6, 32'h0);
    // only the upper word moves, so the lower alias outputs stay put
    @(posedge clk) b1 <= ~u;
    bus_rd(`ADDR_CFG_ALTERNATE, u);
    bus_wr(`ADDR_LOAD_CTRL, 32'h1);
    repeat (5) @(posedge clk);
    #1 `CHK("reload", m, {usb, od, mul, src, rng, byp, idv, flt})
    bus_rd(`ADDR_CFG_ALTERNATE, ~u);
    bus_rd(`ADDR_LOAD_CTRL, 32'h5);
    stop_test;
  end
endmodule
